// [program_memory_table_read.sv]
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - 16-bit store, 8K/16K/32K words by banks
// - fetch restarts at word zero after reset
// - fetch uses pc, table uses pointer
// - table address is high pointer and low
// - basic read reaches sector 0 only
// - low byte to destination, high to latch
// - basic read offsets into pointer high page
// - table-high latch is software readable and writable
// - every accepted table read takes two instruction cycles
// - four-wire programming, one data pin, clock on reset
// - emulation: debug data two-way, debug clock input
// - debug pins still serve programming on emulation
// - four phases per cycle, pc steps at T1
module program_memory_table_read
    import prog_mem_pkg::*;
#(
    parameter int BANKS = BANKS_DEFAULT,         // 1, 2 or 4
    parameter int AW = PAGE_W + $clog2(BANKS)    // word address width
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // core fetch side
    input wire logic pc_load,                    // core loads a jump target
    input wire logic [AW-1:0] pc_target,
    input wire logic pc_hold,                    // core stalls the increment
    output logic [AW-1:0] pc_o,
    output logic [WORD_W-1:0] fetch_word_o,
    output logic t1_o,
    // core table read side
    input wire logic table_read,                 // start of a table read
    input wire logic ext_table_read_op,          // extended form
    input wire logic [7:0] table_ptr_low,
    input wire logic [7:0] table_ptr_high,
    input wire logic [1:0] dest_sector,
    input wire logic [7:0] dest_addr,
    output logic busy_o,
    output logic wr_en_o,                        // destination write strobe
    output logic [7:0] wr_addr_o,
    output logic [1:0] wr_sector_o,
    output logic [7:0] wr_data_o,
    output logic illegal_o,                      // basic form refused
    // table-high latch access
    input wire logic latch_we,
    input wire logic [7:0] latch_wdata,
    output logic [7:0] table_high_latch,
    // store load port, driven by the external programming engine
    input wire logic store_we,
    input wire logic [AW-1:0] store_addr,
    input wire logic [WORD_W-1:0] store_wdata,
    // programming and debug pins
    input wire logic emulation_mode,             // strap, sampled after reset
    input wire logic prog_serial_data_i,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe,
    input wire logic prog_serial_clock,          // shares external_reset_pin
    input wire logic debug_data_pin_i,
    output logic debug_data_pin_o,
    output logic debug_data_pin_oe,
    input wire logic debug_clock_pin,
    input wire logic link_data_out,              // from external link engine
    input wire logic link_data_oe,
    output logic link_data_in_o,
    output logic link_clock_o,
    output logic pin_func_enable_o               // shared user functions live
);

    localparam int DEPTH = BANKS << PAGE_W;

    // program store, flip-flops indexed by word address
    logic [WORD_W-1:0] store_q [DEPTH];

    // phase generator
    logic t1;
    logic t4;

    // the phase code itself is not needed here, only the strobes
    phase_gen u_phase (
        .clk(clk),
        .rst_n(rst_n),
        .t1_o(t1),
        .t4_o(t4),
        .phase_o()
    );

    // program counter
    logic [AW-1:0] pc_q;
    logic [AW-1:0] pc_d;
    logic [WORD_W-1:0] fetch_q;

    // table read state
    tread_e tr_q;
    tread_e tr_d;
    logic [AW-1:0] taddr_q;                  // latched table address
    logic [7:0] dest_q;
    logic [1:0] sect_q;
    logic [WORD_W-1:0] tword_q;              // word captured in first cycle
    logic busy_q;
    logic wr_en_q;
    logic [7:0] wr_addr_q;
    logic [1:0] wr_sector_q;
    logic [7:0] wr_data_q;
    logic illegal_q;
    logic [7:0] latch_q;

    // strap and pin registers
    logic emu_q;
    logic strap_done_q;
    logic pdata_o_q;
    logic pdata_oe_q;
    logic ddata_o_q;
    logic ddata_oe_q;
    logic link_in_q;
    logic link_clk_q;
    logic func_en_q;

    // decode of a table read request
    wire legal_req = ext_table_read_op || (dest_sector == SECTOR_BASIC);
    wire start_req = table_read && (tr_q == TR_IDLE) && t4;
    // pointer pair forms the word address; the high byte picks the page
    wire [15:0] ptr_full = {table_ptr_high, table_ptr_low};
    wire [AW-1:0] tbl_addr = ptr_full[AW-1:0];
    // last phase of the second cycle closes the read
    wire tr_finish = (tr_q == TR_SECOND) && t4;

    // pc steps at T1 unless the core holds or jumps
    assign pc_d = pc_load ? pc_target : (pc_hold ? pc_q : pc_q + AW'(1));

    // table read sequencer: request at T4, two full cycles follow
    always_comb begin
        tr_d = tr_q;
        unique case (tr_q)
            TR_IDLE: if (start_req && legal_req) tr_d = TR_FIRST;
            TR_FIRST: if (t4) tr_d = TR_SECOND;
            TR_SECOND: if (t4) tr_d = TR_IDLE;
            default: tr_d = TR_IDLE;
        endcase
    end

    // store writes come only from the programming engine
    always_ff @(posedge clk) begin
        if (store_we) begin
            store_q[store_addr] <= store_wdata;
        end
    end

    // fetch path: pc advances as T1 begins, word read at T1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= AW'(RESET_VECTOR);
            fetch_q <= ERASED_WORD;
        end else begin
            if (t4) pc_q <= pc_d;
            if (t1) fetch_q <= store_q[pc_q];
        end
    end

    // table state and captured request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tr_q <= TR_IDLE;
            taddr_q <= '0;
            dest_q <= 8'h00;
            sect_q <= 2'h0;
            tword_q <= '0;
            busy_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            tr_q <= tr_d;
            busy_q <= (tr_d != TR_IDLE);
            illegal_q <= start_req && !legal_req;
            if (start_req && legal_req) begin
                taddr_q <= tbl_addr;
                dest_q <= dest_addr;
                sect_q <= dest_sector;
            end
            // word read uses the separate pointer, not the pc
            if (tr_q == TR_FIRST && t4) tword_q <= store_q[taddr_q];
        end
    end

    // destination write strobe, one clock at the close of cycle two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_sector_q <= 2'h0;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= tr_finish;
            if (tr_finish) begin
                wr_addr_q <= dest_q;
                wr_sector_q <= sect_q;
                wr_data_q <= tword_q[7:0];
            end
        end
    end

    // table-high latch: hardware load wins over a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= LATCH_RESET;
        end else if (tr_finish) begin
            latch_q <= tword_q[15:8];
        end else if (latch_we) begin
            latch_q <= latch_wdata;
        end
    end

    // emulation strap is caught once, on the first clock after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            emu_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            emu_q <= emulation_mode;
            strap_done_q <= 1'b1;
        end
    end

    // pin routing; the link engine itself sits outside this block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pdata_o_q <= 1'b0;
            pdata_oe_q <= 1'b0;
            ddata_o_q <= 1'b0;
            ddata_oe_q <= 1'b0;
            link_in_q <= 1'b0;
            link_clk_q <= 1'b0;
            func_en_q <= 1'b1;
        end else begin
            // programming pins carry the link only on the normal part
            pdata_o_q <= link_data_out;
            // no pin is driven before the strap is known, else one clock could fight the host
            pdata_oe_q <= link_data_oe && strap_done_q && !emu_q;
            // debug data pin is two-way only on the emulation part
            ddata_o_q <= link_data_out;
            ddata_oe_q <= link_data_oe && strap_done_q && emu_q;
            link_in_q <= emu_q ? debug_data_pin_i : prog_serial_data_i;
            link_clk_q <= emu_q ? debug_clock_pin : prog_serial_clock;
            func_en_q <= !emu_q;
        end
    end

    // outputs straight from flip-flops
    assign pc_o = pc_q;
    assign fetch_word_o = fetch_q;
    assign t1_o = t1;
    assign busy_o = busy_q;
    assign wr_en_o = wr_en_q;
    assign wr_addr_o = wr_addr_q;
    assign wr_sector_o = wr_sector_q;
    assign wr_data_o = wr_data_q;
    assign illegal_o = illegal_q;
    assign table_high_latch = latch_q;
    assign prog_serial_data_o = pdata_o_q;
    assign prog_serial_data_oe = pdata_oe_q;
    assign debug_data_pin_o = ddata_o_q;
    assign debug_data_pin_oe = ddata_oe_q;
    assign link_data_in_o = link_in_q;
    assign link_clock_o = link_clk_q;
    assign pin_func_enable_o = func_en_q;

endmodule

`default_nettype wire

// [prog_mem_pkg.sv]
package prog_mem_pkg;

    // store geometry
    localparam int WORD_W = 16;
    localparam int PAGE_W = 13;           // words per bank address bits (8K)
    localparam int BANKS_DEFAULT = 4;     // 32K words variant
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // clocking: four phases per instruction cycle
    localparam int CLK_HZ = 25000000;
    localparam int PHASES = 4;
    localparam int TABLE_CYCLES = 2;      // instruction cycles per table read

    // sector number that the basic table read may reach
    localparam logic [1:0] SECTOR_BASIC = 2'h0;

    // instruction cycle phases, gray along the way
    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b11,
        PH_T4 = 2'b10
    } phase_e;

    // table read sequence
    typedef enum logic [1:0] {
        TR_IDLE = 2'b00,
        TR_FIRST = 2'b01,
        TR_SECOND = 2'b11
    } tread_e;

    // next phase in the T1..T4 ring
    function automatic phase_e next_phase(input phase_e p);
        unique case (p)
            PH_T1: next_phase = PH_T2;
            PH_T2: next_phase = PH_T3;
            PH_T3: next_phase = PH_T4;
            PH_T4: next_phase = PH_T1;
        endcase
    endfunction

endpackage

// [phase_gen.sv]
`timescale 1ns/1ns
`default_nettype none

// divides the system clock into four non-overlapping phases
module phase_gen
    import prog_mem_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // phase strobes
    output logic t1_o,
    output logic t4_o,
    output phase_e phase_o
);

    phase_e phase_q; // current phase
    phase_e phase_d;
    logic t1_q; // registered T1 flag, so the top can hand it out from a flop

    assign phase_d = next_phase(phase_q);
    assign phase_o = phase_q;
    assign t1_o = t1_q;
    assign t4_o = (phase_q == PH_T4);

    // ring through T1..T4, starting at T1 after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_T1;
            t1_q <= 1'b1;
        end else begin
            phase_q <= phase_d;
            t1_q <= (phase_d == PH_T1); // same timing as a decode of phase_q
        end
    end

endmodule

`default_nettype wire

// [tmr_props.sv]
`timescale 1ns/1ns
`default_nettype none
// timing relations of the table read and phase ring, seen at the ports
module tmr_props #(
    parameter int AW = 15
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic t1_o,
    input wire logic [AW-1:0] pc_o,
    input wire logic table_read,
    input wire logic busy_o,
    input wire logic wr_en_o,
    input wire logic [7:0] wr_data_o,
    input wire logic illegal_o,
    input wire logic latch_we,
    input wire logic [7:0] table_high_latch
);
    // live from the second edge after release: the release edge still shows reset values
    logic live_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !live_q);
    a_phase_ring: assert property (t1_o |=> !t1_o [*3] ##1 t1_o)
        else $error("phase ring broken");
    a_pc_at_t1: assert property ($changed(pc_o) |-> t1_o)
        else $error("pc moved outside T1");
    a_read_len: assert property ($rose(busy_o) |-> busy_o [*8] ##1 (!busy_o && wr_en_o))
        else $error("table read length wrong");
    a_take_t4: assert property ($rose(busy_o) |-> t1_o && $past(table_read))
        else $error("read taken off T4");
    a_wr_pulse: assert property (wr_en_o |=> !wr_en_o)
        else $error("write strobe too long");
    a_data_cause: assert property ($changed(wr_data_o) |-> wr_en_o)
        else $error("data moved without strobe");
    a_latch_cause: assert property ($changed(table_high_latch) |-> wr_en_o || $past(latch_we))
        else $error("latch moved without cause");
    a_refuse_quiet: assert property (illegal_o |-> !busy_o && !wr_en_o)
        else $error("refused read went ahead");
endmodule
`default_nettype wire

// [core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// core side: raises a table read and holds it until the block takes it
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // block status
    input wire logic t1_o,
    input wire logic busy_o,
    // bench command
    input wire logic go,
    // request to the block
    output logic table_read
);
    logic [1:0] ph_q; // 3 means the T4 cycle
    // follow the instruction cycle from the T1 strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= t1_o ? 2'h1 : ph_q + 2'h1;
        end
    end
    // held request, dropped only on the T4 edge that takes it, so reads never overlap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table_read <= 1'h0;
        end else if (go) begin
            table_read <= 1'h1;
        end else if (ph_q == 2'h3 && !busy_o) begin
            table_read <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module tb;
    localparam int AW = 15;
    logic clk = 1'h0, rst_n = 1'h0, go = 1'h0, host_dat = 1'h1; // bench side
    logic pc_load = 1'h0, pc_hold = 1'h0, ext_table_read_op = 1'h0, latch_we = 1'h0, store_we = 1'h0;
    logic emulation_mode = 1'h0, prog_serial_clock = 1'h0, debug_clock_pin = 1'h0;
    logic link_data_out = 1'h0, link_data_oe = 1'h0;
    logic [AW-1:0] pc_target = '0, store_addr = '0, pc_o;
    logic [15:0] store_wdata = '0, fetch_word_o;
    logic [7:0] table_ptr_low = '0, table_ptr_high = '0, dest_addr = '0, latch_wdata = '0;
    logic [7:0] wr_addr_o, wr_data_o, table_high_latch;
    logic [1:0] dest_sector = '0, wr_sector_o;
    logic t1_o, busy_o, wr_en_o, illegal_o, table_read, prog_serial_data_o, prog_serial_data_oe;
    logic debug_data_pin_o, debug_data_pin_oe, link_data_in_o, link_clock_o, pin_func_enable_o;
    // host drives the pins only while the block lets go of them
    wire logic prog_serial_data_i = prog_serial_data_oe ? prog_serial_data_o : host_dat;
    wire logic debug_data_pin_i = debug_data_pin_oe ? debug_data_pin_o : host_dat;
    int num_errors = 0, n_checks = 0;
    program_memory_table_read u_program_memory_table_read (.*);
    core_model u_core_model (.*);
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one word into the store
    task automatic store(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk);
        store_we <= 1'h1;
        store_addr <= a;
        store_wdata <= d;
        @(posedge clk);
        store_we <= 1'h0;
    endtask
    // one table read through the core model; counts busy cycles
    task automatic rd(input logic [7:0] hi, lo, input logic x, input logic [1:0] s, input logic [7:0] d,
                      output int nb);
        nb = 0;
        @(posedge clk);
        table_ptr_high <= hi;
        table_ptr_low <= lo;
        ext_table_read_op <= x;
        dest_sector <= s;
        dest_addr <= d;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        for (int i = 0; i < 40 && wr_en_o !== 1'h1 && illegal_o !== 1'h1; i++) begin
            @(posedge clk);
            #1;
            nb += (busy_o === 1'h1);
        end
        // a read that never answers within the limit counts as a mismatch
        `CHK(wr_en_o | illegal_o, 1'h1)
    endtask
    // back-to-back basic reads inside one page
    task automatic t_table;
        int nb;
        rd(8'h7F, 8'h06, 1'h0, 2'h0, 8'h21, nb);
        `CHK(nb, 8)
        `CHK(wr_data_o, 8'h1A)
        `CHK(wr_addr_o, 8'h21)
        rd(8'h7F, 8'h05, 1'h0, 2'h0, 8'h22, nb);
        `CHK(wr_data_o, 8'h0F)
        `CHK(table_high_latch, 8'hA5)
    endtask
    // extended read into another sector, then a refused basic one
    task automatic t_sector;
        int nb;
        rd(8'h12, 8'h34, 1'h1, 2'h2, 8'h40, nb);
        `CHK(wr_sector_o, 2'h2)
        `CHK(table_high_latch, 8'h5A)
        rd(8'h7F, 8'h06, 1'h0, 2'h1, 8'h41, nb);
        `CHK(illegal_o, 1'h1)
        `CHK(nb, 0)
        `CHK(table_high_latch, 8'h5A)
    endtask
    // software writes the latch
    task automatic t_latch;
        @(posedge clk);
        latch_we <= 1'h1;
        latch_wdata <= 8'hC3;
        @(posedge clk);
        latch_we <= 1'h0;
        #1;
        `CHK(table_high_latch, 8'hC3)
    endtask
    // jump and stall the fetch path
    task automatic t_fetch;
        @(posedge clk);
        pc_target <= 15'h0100;
        pc_load <= 1'h1;
        repeat (4) @(posedge clk);
        pc_load <= 1'h0;
        pc_hold <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pc_o, 15'h0100)
        `CHK(fetch_word_o, 16'hC3E1)
    endtask
    // normal part: programming pin carries the link both ways
    task automatic t_pins;
        @(posedge clk);
        link_data_oe <= 1'h1;
        link_data_out <= 1'h1;
        prog_serial_clock <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(prog_serial_data_oe, 1'h1)
        `CHK(prog_serial_data_o, 1'h1)
        `CHK(link_clock_o, 1'h1)
        `CHK(pin_func_enable_o, 1'h1)
        @(posedge clk);
        link_data_oe <= 1'h0;
        host_dat <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(link_data_in_o, 1'h0)
    endtask
    // second reset as the emulation part, fetch held at the vector
    task automatic t_emul;
        @(posedge clk);
        rst_n <= 1'h0;
        emulation_mode <= 1'h1;
        link_data_oe <= 1'h1;
        debug_clock_pin <= 1'h1;
        prog_serial_clock <= 1'h0; // opposite level, so the clock select shows
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        `CHK(pc_o, 15'h0000)
        // strap not yet known on the first edge: no pin may be driven
        @(posedge clk);
        #1;
        `CHK(prog_serial_data_oe, 1'h0)
        repeat (5) @(posedge clk);
        #1;
        `CHK(fetch_word_o, 16'h1234)
        `CHK(pin_func_enable_o, 1'h0)
        `CHK(prog_serial_data_oe, 1'h0)
        `CHK(debug_data_pin_oe, 1'h1)
        `CHK(debug_data_pin_o, 1'h1)
        `CHK(link_clock_o, 1'h1)
        `CHK(link_data_in_o, 1'h1)
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        store(15'h0000, 16'h1234);
        store(15'h7F06, 16'h001A);
        store(15'h7F05, 16'hA50F);
        store(15'h1234, 16'h5AA5);
        store(15'h0100, 16'hC3E1);
        t_table;
        t_sector;
        t_latch;
        t_fetch;
        t_pins;
        t_emul;
        test_done;
    end
    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #(40 * 5000);
        num_errors++;
        test_done;
    end
endmodule
bind program_memory_table_read tmr_props #(.AW(AW)) u_tmr_props (.*);
`default_nettype wire
